// *** pkg/mfti_pkg.sv ***
// Operation
// - Write FIFO nearly-full level sits in bits 3:0.
// - Read FIFO nearly-empty level sits in bits 7:4.
// - Enable bit 0 gates read-data underrun.
// - Enable bit 1 gates read-instruction underrun.
// - Enable bit 2 gates write-data underrun.
// - Enable bit 3 gates write-instruction underrun.
// - Enable bit 4 gates read-data overrun.
// - Enable bit 5 gates read-instruction overrun.
// - Enable bit 6 gates write-data overrun.
// - Enable bit 7 gates write-instruction overrun.
// - Read-only status: underruns 3:0, overruns 7:4.
package mfti_pkg;

  localparam int unsigned MFTI_ADDR_W    = 20;
  localparam int unsigned MFTI_DATA_W    = 32;
  localparam int unsigned MFTI_BE_W      = 4;
  localparam int unsigned MFTI_REG_W     = 8;
  localparam int unsigned MFTI_IDX_W     = 18;
  localparam int unsigned MFTI_LEVEL_W   = 4;
  localparam int unsigned MFTI_COUNT_W   = 5;
  localparam int unsigned MFTI_NUM_FLAGS = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [17:0] MFTI_IDX_THRESH = 18'h30b00;
  localparam logic [17:0] MFTI_IDX_ENABLE = 18'h30b01;
  localparam logic [17:0] MFTI_IDX_STATUS = 18'h30b08;
  localparam logic [17:0] MFTI_IDX_MASK   = 18'h30b10;

  // Field positions inside the threshold register.
  localparam int unsigned MFTI_FULL_LSB  = 0;
  localparam int unsigned MFTI_EMPTY_LSB = 4;

  // Values after reset.
  localparam logic [7:0] MFTI_THRESH_RST = 8'h00;
  localparam logic [7:0] MFTI_ENABLE_RST = 8'h00;
  localparam logic [7:0] MFTI_STATUS_RST = 8'h00;
  localparam logic [7:0] MFTI_MASK_RST   = 8'hff;

  // Flag positions, shared by enable, status and mask.
  localparam int unsigned MFTI_RD_DATA_UNDER  = 0;
  localparam int unsigned MFTI_RD_INSTR_UNDER = 1;
  localparam int unsigned MFTI_WR_DATA_UNDER  = 2;
  localparam int unsigned MFTI_WR_INSTR_UNDER = 3;
  localparam int unsigned MFTI_RD_DATA_OVER   = 4;
  localparam int unsigned MFTI_RD_INSTR_OVER  = 5;
  localparam int unsigned MFTI_WR_DATA_OVER   = 6;
  localparam int unsigned MFTI_WR_INSTR_OVER  = 7;

  typedef enum logic {
    MFTI_BUS_IDLE,
    MFTI_BUS_ANSWER
  } mfti_bus_e;

endpackage

// *** pkg/mfti_flag_if.sv ***
`timescale 1ns/100ps
interface mfti_flag_if;
  import mfti_pkg::*;

  logic [MFTI_NUM_FLAGS-1:0] event_hit;
  logic [MFTI_NUM_FLAGS-1:0] enable;
  logic [MFTI_NUM_FLAGS-1:0] read_clear;
  logic [MFTI_NUM_FLAGS-1:0] flags;

  modport bank (
    input  event_hit,
    input  enable,
    input  read_clear,
    output flags
  );

  modport ctrl (
    output event_hit,
    output enable,
    output read_clear,
    input  flags
  );
endinterface

// *** rtl/mfti_flag_bank.sv ***
`timescale 1ns/100ps
module mfti_flag_bank
  import mfti_pkg::*;
(
  // Clock and reset.
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // Event, enable and clear vectors in, sticky flags out.
  mfti_flag_if.bank  flag_bus
);

  logic [MFTI_NUM_FLAGS-1:0] next_flags;

  genvar i;
  generate
    for (i = 0; i < MFTI_NUM_FLAGS; i++) begin : g_flag
      // A gated event in the same cycle as the read clear wins, so no event is lost.
      assign next_flags[i] = (flag_bus.event_hit[i] && flag_bus.enable[i]) ? 1'b1 :
                             flag_bus.read_clear[i] ? 1'b0 : flag_bus.flags[i];
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_bus.flags <= MFTI_STATUS_RST;
    end else begin
      flag_bus.flags <= next_flags;
    end
  end

endmodule

// *** rtl/mfti_ctrl.sv ***
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
module mfti_ctrl
  import mfti_pkg::*;
(
  // Clock and reset.
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // Avalon-MM register slave.
  input  wire logic [MFTI_ADDR_W-1:0]    avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [MFTI_DATA_W-1:0]    avs_writedata_in,
  input  wire logic [MFTI_BE_W-1:0]      avs_byteenable_in,
  output logic      [MFTI_DATA_W-1:0]    avs_readdata_out,
  output logic                           avs_waitrequest_out,
  // FIFO levels and error events from the memory controller.
  input  wire logic [MFTI_COUNT_W-1:0]   wr_data_free_slots_in,
  input  wire logic [MFTI_COUNT_W-1:0]   rd_data_fill_slots_in,
  input  wire logic [MFTI_NUM_FLAGS-1:0] fifo_err_event_in,
  // Level flags, status and interrupt.
  output logic                           wr_data_nearly_full_flag_out,
  output logic                           rd_data_nearly_empty_flag_out,
  output logic      [MFTI_NUM_FLAGS-1:0] fifo_err_flags_out,
  output logic                           memctl_fifo_err_irq_out
);

  logic [MFTI_REG_W-1:0]   fifo_flag_thresholds;
  logic [MFTI_REG_W-1:0]   fifo_error_event_enables;
  logic [MFTI_REG_W-1:0]   fifo_error_irq_mask;
  logic [MFTI_LEVEL_W-1:0] wr_almost_full_level;
  logic [MFTI_LEVEL_W-1:0] rd_almost_empty_level;
  mfti_bus_e               bus_state;
  logic                    bus_req;
  logic                    bus_start;
  logic                    bus_accept;
  logic [MFTI_IDX_W-1:0]   reg_idx;
  logic                    lane0;
  logic                    hit_thresh;
  logic                    hit_enable;
  logic                    hit_status;
  logic                    hit_mask;
  logic [MFTI_DATA_W-1:0]  next_readdata;

  mfti_flag_if flag_bus ();

  assign wr_almost_full_level  = fifo_flag_thresholds[MFTI_FULL_LSB +: MFTI_LEVEL_W];
  assign rd_almost_empty_level = fifo_flag_thresholds[MFTI_EMPTY_LSB +: MFTI_LEVEL_W];

  // Bus decode. Every access takes two cycles so read data can come from a flop.
  assign bus_req    = avs_read_in || avs_write_in;
  assign bus_start  = bus_req && (bus_state == MFTI_BUS_IDLE);
  assign bus_accept = bus_req && (bus_state == MFTI_BUS_ANSWER);
  assign reg_idx    = avs_address_in[MFTI_ADDR_W-1:2];
  assign lane0      = avs_byteenable_in[0];
  assign hit_thresh = (reg_idx == MFTI_IDX_THRESH);
  assign hit_enable = (reg_idx == MFTI_IDX_ENABLE);
  assign hit_status = (reg_idx == MFTI_IDX_STATUS);
  assign hit_mask   = (reg_idx == MFTI_IDX_MASK);

  assign avs_waitrequest_out = bus_req && (bus_state == MFTI_BUS_IDLE);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_state <= MFTI_BUS_IDLE;
    end else begin
      case (bus_state)
        MFTI_BUS_IDLE: begin
          if (bus_req) begin
            bus_state <= MFTI_BUS_ANSWER;
          end
        end
        MFTI_BUS_ANSWER: begin
          bus_state <= MFTI_BUS_IDLE;
        end
        default: begin
          bus_state <= MFTI_BUS_IDLE;
        end
      endcase
    end
  end

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    next_readdata = '0;
    case (reg_idx)
      MFTI_IDX_THRESH: begin
        next_readdata[MFTI_REG_W-1:0] = fifo_flag_thresholds;
      end
      MFTI_IDX_ENABLE: begin
        next_readdata[MFTI_REG_W-1:0] = fifo_error_event_enables;
      end
      MFTI_IDX_STATUS: begin
        next_readdata[MFTI_REG_W-1:0] = flag_bus.flags;
      end
      MFTI_IDX_MASK: begin
        next_readdata[MFTI_REG_W-1:0] = fifo_error_irq_mask;
      end
      default: begin
        next_readdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= '0;
    end else if (bus_start && avs_read_in) begin
      avs_readdata_out <= next_readdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fifo_flag_thresholds <= MFTI_THRESH_RST;
    end else if (bus_accept && avs_write_in && hit_thresh && lane0) begin
      fifo_flag_thresholds <= avs_writedata_in[MFTI_REG_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fifo_error_event_enables <= MFTI_ENABLE_RST;
    end else if (bus_accept && avs_write_in && hit_enable && lane0) begin
      fifo_error_event_enables <= avs_writedata_in[MFTI_REG_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fifo_error_irq_mask <= MFTI_MASK_RST;
    end else if (bus_accept && avs_write_in && hit_mask && lane0) begin
      fifo_error_irq_mask <= avs_writedata_in[MFTI_REG_W-1:0];
    end
  end

  // Level flags; a zero level still fires once the count itself reaches zero.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_data_nearly_full_flag_out  <= 1'b0;
      rd_data_nearly_empty_flag_out <= 1'b0;
    end else begin
      wr_data_nearly_full_flag_out  <= (wr_data_free_slots_in <= {1'b0, wr_almost_full_level});
      rd_data_nearly_empty_flag_out <= (rd_data_fill_slots_in <= {1'b0, rd_almost_empty_level});
    end
  end

  // Only the bits that software actually saw are cleared, so a flag set after the
  // read data was latched survives the read.
  assign flag_bus.event_hit  = fifo_err_event_in;
  assign flag_bus.enable     = fifo_error_event_enables;
  assign flag_bus.read_clear = (bus_accept && avs_read_in && hit_status) ?
                               avs_readdata_out[MFTI_REG_W-1:0] : '0;

  mfti_flag_bank u_flag_bank (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .flag_bus   (flag_bus.bank)
  );

  assign fifo_err_flags_out = flag_bus.flags;

  // The enable term is applied again here so that disabling a source silences it at once.
  assign memctl_fifo_err_irq_out = |(flag_bus.flags & fifo_error_event_enables & fifo_error_irq_mask);

  default clocking cb @(posedge clk_in);
  endclocking

  default disable iff (sys_rst_in);

  sequence s_read_start(logic [17:0] idx);
    bus_start && avs_read_in && (reg_idx == idx);
  endsequence

  sequence s_write_take(logic [17:0] idx);
    bus_accept && avs_write_in && (reg_idx == idx) && lane0;
  endsequence

  property p_wait_once;
    bus_start |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("Waitrequest did not drop on the second cycle.");

  property p_reset_vals;
    @(posedge clk_in) disable iff (1'b0)
    sys_rst_in |=> (fifo_flag_thresholds == 8'h00) && (fifo_error_event_enables == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Control registers not zero after reset.");

  property p_thresh_write;
    s_write_take(MFTI_IDX_THRESH) |=> (fifo_flag_thresholds == $past(avs_writedata_in[7:0]));
  endproperty
  a_thresh_write: assert property (p_thresh_write)
    else $error("Threshold write not stored.");

  property p_enable_write;
    s_write_take(MFTI_IDX_ENABLE) |=> (fifo_error_event_enables == $past(avs_writedata_in[7:0]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable write not stored.");

  property p_thresh_read;
    s_read_start(MFTI_IDX_THRESH) |=> (avs_readdata_out == {24'h000000, $past(fifo_flag_thresholds)});
  endproperty
  a_thresh_read: assert property (p_thresh_read)
    else $error("Threshold read returned wrong data.");

  property p_full_flag;
    if (wr_data_free_slots_in <= {1'b0, wr_almost_full_level})
      (##1 wr_data_nearly_full_flag_out)
    else
      (##1 !wr_data_nearly_full_flag_out);
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("Nearly-full flag does not follow the level.");

  property p_empty_flag;
    if (rd_data_fill_slots_in <= {1'b0, rd_almost_empty_level})
      (##1 rd_data_nearly_empty_flag_out)
    else
      (##1 !rd_data_nearly_empty_flag_out);
  endproperty
  a_empty_flag: assert property (p_empty_flag)
    else $error("Nearly-empty flag does not follow the level.");

  property p_rd_data_under_gate;
    if (fifo_error_event_enables[0]) (fifo_err_event_in[0] |=> fifo_err_flags_out[0])
    else (!fifo_err_flags_out[0] |=> !fifo_err_flags_out[0]);
  endproperty
  a_rd_data_under_gate: assert property (p_rd_data_under_gate)
    else $error("Read-data underrun flag not gated by its enable.");

  property p_rd_instr_under_gate;
    if (fifo_error_event_enables[1]) (fifo_err_event_in[1] |=> fifo_err_flags_out[1])
    else (!fifo_err_flags_out[1] |=> !fifo_err_flags_out[1]);
  endproperty
  a_rd_instr_under_gate: assert property (p_rd_instr_under_gate)
    else $error("Read-instruction underrun flag not gated by its enable.");

  property p_wr_data_under_gate;
    if (fifo_error_event_enables[2]) (fifo_err_event_in[2] |=> fifo_err_flags_out[2])
    else (!fifo_err_flags_out[2] |=> !fifo_err_flags_out[2]);
  endproperty
  a_wr_data_under_gate: assert property (p_wr_data_under_gate)
    else $error("Write-data underrun flag not gated by its enable.");

  property p_wr_instr_under_gate;
    if (fifo_error_event_enables[3]) (fifo_err_event_in[3] |=> fifo_err_flags_out[3])
    else (!fifo_err_flags_out[3] |=> !fifo_err_flags_out[3]);
  endproperty
  a_wr_instr_under_gate: assert property (p_wr_instr_under_gate)
    else $error("Write-instruction underrun flag not gated by its enable.");

  property p_rd_data_over_gate;
    if (fifo_error_event_enables[4]) (fifo_err_event_in[4] |=> fifo_err_flags_out[4])
    else (!fifo_err_flags_out[4] |=> !fifo_err_flags_out[4]);
  endproperty
  a_rd_data_over_gate: assert property (p_rd_data_over_gate)
    else $error("Read-data overrun flag not gated by its enable.");

  property p_rd_instr_over_gate;
    if (fifo_error_event_enables[5]) (fifo_err_event_in[5] |=> fifo_err_flags_out[5])
    else (!fifo_err_flags_out[5] |=> !fifo_err_flags_out[5]);
  endproperty
  a_rd_instr_over_gate: assert property (p_rd_instr_over_gate)
    else $error("Read-instruction overrun flag not gated by its enable.");

  property p_wr_data_over_gate;
    if (fifo_error_event_enables[6]) (fifo_err_event_in[6] |=> fifo_err_flags_out[6])
    else (!fifo_err_flags_out[6] |=> !fifo_err_flags_out[6]);
  endproperty
  a_wr_data_over_gate: assert property (p_wr_data_over_gate)
    else $error("Write-data overrun flag not gated by its enable.");

  property p_wr_instr_over_gate;
    if (fifo_error_event_enables[7]) (fifo_err_event_in[7] |=> fifo_err_flags_out[7])
    else (!fifo_err_flags_out[7] |=> !fifo_err_flags_out[7]);
  endproperty
  a_wr_instr_over_gate: assert property (p_wr_instr_over_gate)
    else $error("Write-instruction overrun flag not gated by its enable.");

  property p_status_read;
    s_read_start(MFTI_IDX_STATUS) |=> (avs_readdata_out == {24'h000000, $past(fifo_err_flags_out)});
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read returned wrong data.");

  property p_status_clear;
    (bus_accept && avs_read_in && hit_status && !(|(fifo_err_event_in & fifo_error_event_enables)))
      |=> ((fifo_err_flags_out & $past(avs_readdata_out[7:0])) == 8'h00);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("Status bits not cleared by the read.");

  property p_irq_raise;
    (|(fifo_err_event_in & fifo_error_event_enables & fifo_error_irq_mask))
      ##1 (fifo_error_event_enables == $past(fifo_error_event_enables)) &&
          (fifo_error_irq_mask == $past(fifo_error_irq_mask))
      |-> memctl_fifo_err_irq_out;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("Interrupt missing after an enabled event.");

  property p_irq_cause;
    memctl_fifo_err_irq_out |-> (|(fifo_err_flags_out & fifo_error_event_enables));
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("Interrupt high with no enabled flag set.");

  property p_unmapped_read;
    (bus_start && avs_read_in && !hit_thresh && !hit_enable && !hit_status && !hit_mask)
      |=> (avs_readdata_out == 32'h00000000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read did not return zero.");

endmodule

// *** bench/mfti_fifo_user.sv ***
`timescale 1ns/100ps
module mfti_fifo_user
  import mfti_pkg::*;
(
  // Clock.
  input  wire logic                      clk_in,
  // Levels and error events toward the controller.
  output logic      [MFTI_COUNT_W-1:0]   free_slots_out,
  output logic      [MFTI_COUNT_W-1:0]   fill_slots_out,
  output logic      [MFTI_NUM_FLAGS-1:0] err_event_out
);
  // Idle start: write FIFO empty, read FIFO full, so neither level flag is near its limit.
  initial begin
    free_slots_out = 5'h1f;
    fill_slots_out = 5'h1f;
    err_event_out  = 8'h00;
  end

  task automatic set_levels(input logic [MFTI_COUNT_W-1:0] free, input logic [MFTI_COUNT_W-1:0] fill);
    @(posedge clk_in);
    free_slots_out <= free;
    fill_slots_out <= fill;
  endtask

  // A real FIFO flags an overrun or underrun on a single push or pop, so events are one-cycle pulses.
  task automatic pulse(input logic [MFTI_NUM_FLAGS-1:0] ev);
    @(posedge clk_in);
    err_event_out <= ev;
    @(posedge clk_in);
    err_event_out <= 8'h00;
  endtask
endmodule

// *** bench/memctl_fifo_threshold_irq_bench.sv ***
`timescale 1ns/100ps
module memctl_fifo_threshold_irq_bench;
  import mfti_pkg::*;

  logic                      clk_in;
  logic                      sys_rst_in;
  logic [MFTI_ADDR_W-1:0]    avs_address_in;
  logic                      avs_read_in;
  logic                      avs_write_in;
  logic [MFTI_DATA_W-1:0]    avs_writedata_in;
  logic [MFTI_BE_W-1:0]      avs_byteenable_in;
  logic [MFTI_DATA_W-1:0]    avs_readdata_out;
  logic                      avs_waitrequest_out;
  logic [MFTI_COUNT_W-1:0]   free_slots;
  logic [MFTI_COUNT_W-1:0]   fill_slots;
  logic [MFTI_NUM_FLAGS-1:0] err_event;
  logic                      full_flag;
  logic                      empty_flag;
  logic [MFTI_NUM_FLAGS-1:0] err_flags;
  logic                      irq;
  logic [MFTI_DATA_W-1:0]    rdata;
  int                        err_total;
  int                        compares;

`define check_eq(act, exp) begin compares++; if ((act) !== (exp)) begin err_total++; \
  $display("Error at %0t: got %h, expected %h", $time, (act), (exp)); end end

  mfti_ctrl dut_u (
    .clk_in                        (clk_in),
    .sys_rst_in                    (sys_rst_in),
    .avs_address_in                (avs_address_in),
    .avs_read_in                   (avs_read_in),
    .avs_write_in                  (avs_write_in),
    .avs_writedata_in              (avs_writedata_in),
    .avs_byteenable_in             (avs_byteenable_in),
    .avs_readdata_out              (avs_readdata_out),
    .avs_waitrequest_out           (avs_waitrequest_out),
    .wr_data_free_slots_in         (free_slots),
    .rd_data_fill_slots_in         (fill_slots),
    .fifo_err_event_in             (err_event),
    .wr_data_nearly_full_flag_out  (full_flag),
    .rd_data_nearly_empty_flag_out (empty_flag),
    .fifo_err_flags_out            (err_flags),
    .memctl_fifo_err_irq_out       (irq)
  );

  mfti_fifo_user user_u (
    .clk_in         (clk_in),
    .free_slots_out (free_slots),
    .fill_slots_out (fill_slots),
    .err_event_out  (err_event)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The request stands until an edge that sees waitrequest low; that edge alone takes the data.
  task automatic bus_xfer(input logic wr, input logic [17:0] idx, input logic [7:0] wd, input logic [3:0] be);
    int n;
    @(posedge clk_in);
    avs_address_in    <= {idx, 2'b00};
    avs_writedata_in  <= {24'h000000, wd};
    avs_byteenable_in <= be;
    avs_read_in       <= ~wr;
    avs_write_in      <= wr;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
      if (n > 50) begin
        err_total++;
        $display("Error at %0t: bus answer timed out", $time);
        end_sim();
      end
    end while (avs_waitrequest_out !== 1'b0);
    rdata = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [17:0] idx, input logic [7:0] exp);
    bus_xfer(1'b0, idx, 8'h00, 4'hf);
    `check_eq(rdata, {24'h000000, exp})
  endtask

  task automatic test_reset();
    rd_chk(MFTI_IDX_THRESH, 8'h00);
    rd_chk(MFTI_IDX_ENABLE, 8'h00);
    rd_chk(MFTI_IDX_STATUS, 8'h00);
    rd_chk(MFTI_IDX_MASK, 8'hff);
    `check_eq(irq, 1'b0)
    $display("test reset done");
  endtask

  // Level 4 for the full flag and 10 for the empty flag; each side is probed below, at and above.
  task automatic test_levels();
    bus_xfer(1'b1, MFTI_IDX_THRESH, 8'ha4, 4'h1);
    rd_chk(MFTI_IDX_THRESH, 8'ha4);
    for (int k = 3; k <= 5; k++) begin
      user_u.set_levels(5'(k), 5'h1f);
      @(posedge clk_in);
      #1;
      `check_eq(full_flag, 1'(k <= 4))
      `check_eq(empty_flag, 1'b0)
    end
    for (int k = 9; k <= 11; k++) begin
      user_u.set_levels(5'h1f, 5'(k));
      @(posedge clk_in);
      #1;
      `check_eq(empty_flag, 1'(k <= 10))
      `check_eq(full_flag, 1'b0)
    end
    $display("test levels done");
  endtask

  task automatic test_enables();
    for (int i = 0; i < 8; i++) begin
      bus_xfer(1'b1, MFTI_IDX_ENABLE, ~(8'h01 << i), 4'h1);
      user_u.pulse(8'h01 << i);
      #1;
      `check_eq(err_flags, 8'h00)
      `check_eq(irq, 1'b0)
      bus_xfer(1'b1, MFTI_IDX_ENABLE, 8'h01 << i, 4'h1);
      user_u.pulse(8'hff);
      #1;
      `check_eq(err_flags, 8'h01 << i)
      `check_eq(irq, 1'b1)
      rd_chk(MFTI_IDX_STATUS, 8'h01 << i);
      #1;
      `check_eq(err_flags, 8'h00)
      `check_eq(irq, 1'b0)
    end
    $display("test enables done");
  endtask

  task automatic test_gate();
    bus_xfer(1'b1, MFTI_IDX_ENABLE, 8'h44, 4'h1);
    user_u.pulse(8'h04);
    #1;
    `check_eq(irq, 1'b1)
    bus_xfer(1'b1, MFTI_IDX_ENABLE, 8'h00, 4'h1);
    #1;
    `check_eq(irq, 1'b0)
    `check_eq(err_flags, 8'h04)
    bus_xfer(1'b1, MFTI_IDX_ENABLE, 8'h04, 4'h1);
    bus_xfer(1'b1, MFTI_IDX_MASK, 8'h00, 4'h1);
    #1;
    `check_eq(irq, 1'b0)
    bus_xfer(1'b1, MFTI_IDX_MASK, 8'hff, 4'h1);
    #1;
    `check_eq(irq, 1'b1)
    rd_chk(MFTI_IDX_ENABLE, 8'h04);
    rd_chk(MFTI_IDX_STATUS, 8'h04);
    // The clear lands on the accepting edge itself, so the interrupt is looked at once it has settled.
    #1;
    `check_eq(irq, 1'b0)
    $display("test gate done");
  endtask

  // Refused accesses must leave every register untouched; a second reset then clears the writes.
  task automatic test_refused();
    bus_xfer(1'b1, MFTI_IDX_THRESH, 8'h5a, 4'h2);
    rd_chk(MFTI_IDX_THRESH, 8'ha4);
    bus_xfer(1'b1, MFTI_IDX_STATUS, 8'hff, 4'h1);
    rd_chk(MFTI_IDX_STATUS, 8'h00);
    bus_xfer(1'b1, 18'h30b02, 8'h77, 4'h1);
    rd_chk(18'h30b02, 8'h00);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(MFTI_IDX_THRESH, 8'h00);
    rd_chk(MFTI_IDX_ENABLE, 8'h00);
    rd_chk(MFTI_IDX_MASK, 8'hff);
    $display("test refused done");
  endtask

  initial begin
    err_total         = 0;
    compares          = 0;
    sys_rst_in        = 1'b1;
    avs_address_in    = '0;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_writedata_in  = '0;
    avs_byteenable_in = 4'h0;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    test_reset();
    test_levels();
    test_enables();
    test_gate();
    test_refused();
    end_sim();
  end

  initial begin
    repeat (50000) @(posedge clk_in);
    err_total++;
    $display("Error at %0t: run timed out", $time);
    end_sim();
  end
endmodule
